// ==== verilog/ccr_regs.svh ====
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH

// special register number of the configuration register
`define CCR_SPRN        10'h3B3
`define CCR_RESET_VAL   32'h00000000
// writable field mask, little-endian bit index (big-endian bit n sits at 31-n)
`define CCR_WR_MASK     32'h4830E10F
`define CCR_B_PRE       30
`define CCR_B_PAR_READ  27
`define CCR_B_NO_MERGE  21
`define CCR_B_NO_AUX    20
`define CCR_B_NO_TRACE  15
`define CCR_B_G_ITOUCH  14
`define CCR_B_G_DTOUCH  13
`define CCR_B_ALIGN     8
`define CCR_B_SLC_HI    3
`define CCR_B_SLC_LO    2
`define CCR_B_SLT_HI    1
`define CCR_B_SLT_LO    0
`endif

// ==== verilog/ccr_pkg.sv ====
package ccr_pkg;
   typedef struct packed {
      logic       parity_full_recovery;
      logic       parity_readback_enable;
      logic       store_merge_disable;
      logic       aux_processor_broadcast_disable;
      logic       trace_broadcast_disable;
      logic       guaranteed_instr_touch;
      logic       guaranteed_data_touch;
      logic       forced_alignment_check;
      logic [1:0] speculative_line_count;
      logic [1:0] speculative_fill_threshold;
   } ccr_ctrl_s;

   typedef struct packed {
      logic [9:0]  num;
      logic        rd;
      logic        wr;
      logic        sup;
      logic [31:0] wdata;
   } ccr_spr_req_s;

   typedef enum logic [1:0] {
      ACC_IDLE,
      ACC_READ,
      ACC_WRITE,
      ACC_FAULT
   } ccr_acc_e;
endpackage : ccr_pkg

// ==== verilog/ccr_align_chk.sv ====
`timescale 1ns/1ps
module ccr_align_chk #(
   parameter int AW = 32
) (
   // access
   input  wire logic          acc_valid,
   input  wire logic [AW-1:0] acc_addr,
   input  wire logic [1:0]    acc_size_log2,
   // control
   input  wire logic          force_align,
   // result
   output      logic          align_exc
);
   logic [2:0] low_mask;
   logic       misaligned;

   assign low_mask   = (acc_size_log2 == 2'h0) ? 3'h0 :
                       (acc_size_log2 == 2'h1) ? 3'h1 :
                       (acc_size_log2 == 2'h2) ? 3'h3 : 3'h7;
   assign misaligned = |(acc_addr[2:0] & low_mask);
   assign align_exc  = acc_valid & force_align & misaligned;
endmodule : ccr_align_chk

// ==== verilog/ccr_spec_fill.sv ====
`timescale 1ns/1ps
module ccr_spec_fill (
   // fill progress
   input  wire logic       fill_active,
   input  wire logic       redirect,
   input  wire logic [2:0] dw_filled,
   // control
   input  wire logic [1:0] threshold,
   // result
   output      logic       fill_abandon
);
   logic below;

   // a fill that has not reached the threshold is dropped on redirect
   assign below        = dw_filled < {1'b0, threshold};
   assign fill_abandon = fill_active & redirect & below;
endmodule : ccr_spec_fill

// ==== verilog/ccr_core_config.sv ====
`timescale 1ns/1ps
`include "ccr_regs.svh"
module ccr_core_config #(
   parameter logic [31:0] RESET_VAL = `CCR_RESET_VAL,
   parameter int          PAR_W     = 8,
   parameter int          AW        = 32
) (
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 nrst,
   // special register access
   input  wire ccr_pkg::ccr_spr_req_s spr_req,
   output      logic                 spr_hit,
   output      logic                 spr_rd_ack,
   output      logic                 spr_wr_ack,
   output      logic                 spr_priv_fault,
   output      logic [31:0]          spr_rdata,
   // control lines to core units
   output      ccr_pkg::ccr_ctrl_s   ctrl,
   // debug reads parity
   input  wire logic                 dbg_rd_valid,
   input  wire logic [PAR_W-1:0]     icache_par_in,
   input  wire logic [PAR_W-1:0]     dcache_par_in,
   input  wire logic [PAR_W-1:0]     tlb_par_in,
   output      logic [PAR_W-1:0]     instr_debug_tag_high_par,
   output      logic [PAR_W-1:0]     data_debug_tag_low_par,
   output      logic [PAR_W-1:0]     general_register_par,
   // store gathering
   input  wire logic                 st_contiguous,
   output      logic                 st_merge_ok,
   // auxiliary processor and trace
   input  wire logic                 aux_insn_valid_in,
   output      logic                 aux_insn_valid,
   input  wire logic                 trace_valid_in,
   output      logic                 trace_valid,
   // block touches
   input  wire logic                 itouch_active,
   input  wire logic                 ipipe_stall,
   output      logic                 itouch_abandon,
   input  wire logic                 dtouch_active,
   input  wire logic                 lspipe_stall,
   output      logic                 dtouch_abandon,
   // alignment
   input  wire logic                 acc_valid,
   input  wire logic [AW-1:0]        acc_addr,
   input  wire logic [1:0]           acc_size_log2,
   output      logic                 align_exc,
   // speculative prefetch
   input  wire logic                 spec_fill_active,
   input  wire logic                 spec_redirect,
   input  wire logic [2:0]           spec_dw_filled,
   output      logic [1:0]           prefetch_lines,
   output      logic                 spec_fill_abandon
);
   logic [31:0]       cfg_q;
   logic [31:0]       cfg_d;
   logic [31:0]       rdata_q;
   logic [31:0]       rdata_d;
   ccr_pkg::ccr_acc_e acc_q;
   ccr_pkg::ccr_acc_e acc_d;
   logic [PAR_W-1:0]  ipar_q;
   logic [PAR_W-1:0]  dpar_q;
   logic [PAR_W-1:0]  tpar_q;
   logic              sel;
   logic              req_any;
   logic              wr_ok;
   logic              rd_ok;
   logic              fault;

   // decode
   assign sel     = spr_req.num == `CCR_SPRN;
   assign req_any = sel & (spr_req.rd | spr_req.wr);
   assign wr_ok   = sel & spr_req.wr & spr_req.sup;
   assign rd_ok   = sel & spr_req.rd & spr_req.sup & ~spr_req.wr;
   assign fault   = req_any & ~spr_req.sup;
   assign spr_hit = sel;

   // write keeps only the defined fields; reserved positions stay zero
   assign cfg_d   = wr_ok ? (spr_req.wdata & `CCR_WR_MASK) : cfg_q;
   assign rdata_d = rd_ok ? cfg_q : rdata_q;
   assign acc_d   = fault ? ccr_pkg::ACC_FAULT :
                    wr_ok ? ccr_pkg::ACC_WRITE :
                    rd_ok ? ccr_pkg::ACC_READ  : ccr_pkg::ACC_IDLE;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         cfg_q   <= RESET_VAL & `CCR_WR_MASK;
         rdata_q <= 32'h00000000;
         acc_q   <= ccr_pkg::ACC_IDLE;
      end else begin
         cfg_q   <= cfg_d;
         rdata_q <= rdata_d;
         acc_q   <= acc_d;
      end
   end

   // answers one cycle after the request
   always_comb begin
      spr_rd_ack     = 1'b0;
      spr_wr_ack     = 1'b0;
      spr_priv_fault = 1'b0;
      case (acc_q)
         ccr_pkg::ACC_READ:  spr_rd_ack     = 1'b1;
         ccr_pkg::ACC_WRITE: spr_wr_ack     = 1'b1;
         ccr_pkg::ACC_FAULT: spr_priv_fault = 1'b1;
         default:            spr_rd_ack     = 1'b0;
      endcase
   end
   assign spr_rdata = rdata_q;

   // field fan-out
   assign ctrl.parity_full_recovery            = cfg_q[`CCR_B_PRE];
   assign ctrl.parity_readback_enable          = cfg_q[`CCR_B_PAR_READ];
   assign ctrl.store_merge_disable             = cfg_q[`CCR_B_NO_MERGE];
   assign ctrl.aux_processor_broadcast_disable = cfg_q[`CCR_B_NO_AUX];
   assign ctrl.trace_broadcast_disable         = cfg_q[`CCR_B_NO_TRACE];
   assign ctrl.guaranteed_instr_touch          = cfg_q[`CCR_B_G_ITOUCH];
   assign ctrl.guaranteed_data_touch           = cfg_q[`CCR_B_G_DTOUCH];
   assign ctrl.forced_alignment_check          = cfg_q[`CCR_B_ALIGN];
   assign ctrl.speculative_line_count          = cfg_q[`CCR_B_SLC_HI:`CCR_B_SLC_LO];
   assign ctrl.speculative_fill_threshold      = cfg_q[`CCR_B_SLT_HI:`CCR_B_SLT_LO];

   // parity readback, registered with the debug read
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ipar_q <= '0;
         dpar_q <= '0;
         tpar_q <= '0;
      end else if (dbg_rd_valid) begin
         ipar_q <= ctrl.parity_readback_enable ? icache_par_in : '0;
         dpar_q <= ctrl.parity_readback_enable ? dcache_par_in : '0;
         tpar_q <= ctrl.parity_readback_enable ? tlb_par_in : '0;
      end
   end
   assign instr_debug_tag_high_par = ipar_q;
   assign data_debug_tag_low_par   = dpar_q;
   assign general_register_par     = tpar_q;

   // gating of unit strobes; disables also save switching power
   assign st_merge_ok    = st_contiguous & ~ctrl.store_merge_disable;
   assign aux_insn_valid = aux_insn_valid_in & ~ctrl.aux_processor_broadcast_disable;
   assign trace_valid    = trace_valid_in & ~ctrl.trace_broadcast_disable;
   assign itouch_abandon = itouch_active & ipipe_stall & ~ctrl.guaranteed_instr_touch;
   assign dtouch_abandon = dtouch_active & lspipe_stall & ~ctrl.guaranteed_data_touch;
   assign prefetch_lines = ctrl.speculative_line_count;

   ccr_align_chk #(
      .AW (AW)
   ) u_align (
      .acc_valid     (acc_valid),
      .acc_addr      (acc_addr),
      .acc_size_log2 (acc_size_log2),
      .force_align   (ctrl.forced_alignment_check),
      .align_exc     (align_exc)
   );

   ccr_spec_fill u_spec (
      .fill_active  (spec_fill_active),
      .redirect     (spec_redirect),
      .dw_filled    (spec_dw_filled),
      .threshold    (ctrl.speculative_fill_threshold),
      .fill_abandon (spec_fill_abandon)
   );

   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   chk_user_write_ignored: assert property (
      (sel && spr_req.wr && !spr_req.sup) |=> (cfg_q == $past(cfg_q)) && spr_priv_fault)
      else $error("user-state write changed the register");

   chk_read_returns_value: assert property (
      (rd_ok) |=> spr_rd_ack && (spr_rdata == $past(cfg_q)))
      else $error("supervisor read returned wrong data");

   chk_write_lands_masked: assert property (
      (wr_ok) |=> spr_wr_ack && (cfg_q == ($past(spr_req.wdata) & `CCR_WR_MASK)))
      else $error("write did not land with reserved bits cleared");

   chk_hold_without_write: assert property (
      (!wr_ok) |=> $stable(cfg_q))
      else $error("register changed without a supervisor write");

   chk_parity_recovery_bit: assert property (
      (wr_ok) |=> ctrl.parity_full_recovery == $past(spr_req.wdata[`CCR_B_PRE]))
      else $error("parity recovery field not taken from write");

   chk_parity_suppressed: assert property (
      (dbg_rd_valid && !ctrl.parity_readback_enable) |=>
         (instr_debug_tag_high_par == '0) && (data_debug_tag_low_par == '0) && (general_register_par == '0))
      else $error("parity delivered while readback disabled");

   chk_no_merge_disabled: assert property (
      ctrl.store_merge_disable |-> !st_merge_ok)
      else $error("store merged while gathering disabled");

   chk_aux_trace_gated: assert property (
      (ctrl.aux_processor_broadcast_disable |-> !aux_insn_valid) and (ctrl.trace_broadcast_disable |-> !trace_valid))
      else $error("broadcast seen while disabled");

   chk_touch_kept_guaranteed: assert property (
      (ctrl.guaranteed_instr_touch |-> !itouch_abandon) and (ctrl.guaranteed_data_touch |-> !dtouch_abandon))
      else $error("guaranteed touch abandoned");

   chk_align_only_forced: assert property (
      (align_exc |-> ctrl.forced_alignment_check && acc_valid))
      else $error("alignment exception without forced checking");

   chk_spec_threshold: assert property (
      (spec_fill_active && spec_redirect && ({1'b0, ctrl.speculative_fill_threshold} <= spec_dw_filled))
         |-> !spec_fill_abandon)
      else $error("fill abandoned after reaching threshold");

   cov_super_write: cover property (wr_ok ##1 spr_wr_ack);
   cov_user_fault: cover property (fault ##1 spr_priv_fault);
   cov_write_then_read: cover property (wr_ok ##1 rd_ok ##1 spr_rd_ack);
   cov_spec_abandon: cover property (spec_fill_abandon);
endmodule : ccr_core_config

// ==== sim/ccr_core_model.sv ====
`timescale 1ns/1ps
module ccr_core_model (
   // stimulus from bench
   input  wire logic [95:0] stim,
   // debug read parity
   output      logic        dbg_rd_valid,
   output      logic [7:0]  icache_par,
   output      logic [7:0]  dcache_par,
   output      logic [7:0]  tlb_par,
   // stores, broadcast, touches (itouch, istall, dtouch, lsstall)
   output      logic        st_contiguous,
   output      logic        aux_in,
   output      logic        trace_in,
   output      logic [3:0]  touch,
   // alignment and prefetch
   output      logic        acc_valid,
   output      logic [31:0] acc_addr,
   output      logic [1:0]  acc_size,
   output      logic        spec_active,
   output      logic        spec_redirect,
   output      logic [2:0]  spec_dw
);
   // fresh parity every cycle, so a stale capture cannot pass as a match
   assign {dbg_rd_valid, icache_par, dcache_par, tlb_par} = stim[24:0];
   assign {st_contiguous, aux_in, trace_in, touch} = stim[31:25];
   assign {acc_valid, acc_size, spec_active, spec_redirect, spec_dw} = stim[39:32];
   assign acc_addr = stim[95:64];
endmodule : ccr_core_model

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
   localparam logic [31:0] MASK = 32'h4830E10F;
   logic                  clock;
   logic                  nrst;
   ccr_pkg::ccr_spr_req_s spr_req;
   ccr_pkg::ccr_ctrl_s    ctrl;
   logic [95:0]           stim;
   logic [31:0]           spr_rdata, addr, s, m, lastrd;
   logic                  hit_o, rd_ack, wr_ack, fault, dbg_v, st_c, aux_i, tr_i, acc_v, sp_a, sp_r;
   logic                  st_ok, aux_o, tr_o, it_ab, dt_ab, al_x, sp_ab;
   logic [7:0]            ip, dp, tp, ip_o, dp_o, gp_o;
   logic [3:0]            touch;
   logic [1:0]            sz, pl;
   logic [2:0]            dw;
   logic [23:0]           ep;
   logic [34:0]           q[$];
   int                    num_errors, samples_checked;

   ccr_core_model ccr_core_model_inst (.stim(stim), .dbg_rd_valid(dbg_v), .icache_par(ip), .dcache_par(dp),
      .tlb_par(tp), .st_contiguous(st_c), .aux_in(aux_i), .trace_in(tr_i), .touch(touch), .acc_valid(acc_v),
      .acc_addr(addr), .acc_size(sz), .spec_active(sp_a), .spec_redirect(sp_r), .spec_dw(dw));

   ccr_core_config ccr_core_config_inst (.clock(clock), .nrst(nrst), .spr_req(spr_req), .spr_hit(hit_o),
      .spr_rd_ack(rd_ack), .spr_wr_ack(wr_ack), .spr_priv_fault(fault), .spr_rdata(spr_rdata), .ctrl(ctrl),
      .dbg_rd_valid(dbg_v), .icache_par_in(ip), .dcache_par_in(dp), .tlb_par_in(tp),
      .instr_debug_tag_high_par(ip_o), .data_debug_tag_low_par(dp_o), .general_register_par(gp_o),
      .st_contiguous(st_c), .st_merge_ok(st_ok), .aux_insn_valid_in(aux_i), .aux_insn_valid(aux_o),
      .trace_valid_in(tr_i), .trace_valid(tr_o), .itouch_active(touch[3]), .ipipe_stall(touch[2]),
      .itouch_abandon(it_ab), .dtouch_active(touch[1]), .lspipe_stall(touch[0]), .dtouch_abandon(dt_ab),
      .acc_valid(acc_v), .acc_addr(addr), .acc_size_log2(sz), .align_exc(al_x), .spec_fill_active(sp_a),
      .spec_redirect(sp_r), .spec_dw_filled(dw), .prefetch_lines(pl), .spec_fill_abandon(sp_ab));

   function automatic logic [31:0] xs();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : xs

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // main sequence needs about 3015 cycles
   initial begin
      #250000;
      num_errors++;
      stop_test();
   end

   // answers come 5 ns after the taking edge, oldest note first
   always @(posedge clock) begin
      #5;
      if ((rd_ack | wr_ack | fault) !== 1'b0)
         check({fault, wr_ack, rd_ack, spr_rdata}, q.size() > 0 ? q.pop_front() : 35'h0);
   end

   initial begin : main
      logic [31:0] r;
      logic [31:0] r2;
      logic [6:0]  eg;
      logic [14:0] ec;
      logic        hit;
      logic        acc_wr;
      logic        acc_rd;
      nrst = 1'b0;
      spr_req = '0;
      stim = '0;
      s = 32'd28690;
      m = RESET_CHECK_VAL();
      lastrd = '0;
      ep = '0;
      num_errors = 0;
      samples_checked = 0;
      repeat (12) @(posedge clock);
      #1 nrst = 1'b1;
      for (int i = 0; i < 3000; i++) begin
         @(posedge clock);
         #1;
         stim = {xs(), xs(), xs()};
         r = xs();
         r2 = xs();
         spr_req.num = r[1:0] != 2'b00 ? 10'h3B3 : r[11:2];
         spr_req.rd = r[12];
         spr_req.wr = r[13];
         spr_req.sup = |r[15:14];
         spr_req.wdata = r[16] ? r2 & MASK : r2; // reserved zero on half the writes, raw on the rest
         hit = spr_req.num == 10'h3B3;
         acc_wr = hit && spr_req.wr && spr_req.sup;
         acc_rd = hit && spr_req.rd && !spr_req.wr && spr_req.sup;
         if (acc_rd)
            lastrd = m;
         if (hit && (spr_req.rd || spr_req.wr))
            q.push_back({hit && !spr_req.sup, acc_wr, acc_rd, lastrd});
         #5;
         ec = {hit, m[30], m[27], m[21], m[20], m[15], m[14], m[13], m[8], m[3:0], m[3:2]};
         check({hit_o, ctrl, pl}, ec);
         eg = {st_c & ~m[21], aux_i & ~m[20], tr_i & ~m[15], touch[3] & touch[2] & ~m[14],
               touch[1] & touch[0] & ~m[13], acc_v & m[8] & ((addr & ((32'd1 << sz) - 32'd1)) != 32'd0),
               sp_a & sp_r & (dw < {1'b0, m[1:0]})};
         check({st_ok, aux_o, tr_o, it_ab, dt_ab}, eg[6:2]);
         check({al_x, sp_ab}, eg[1:0]);
         check({ip_o, dp_o, gp_o}, ep);
         if (dbg_v)
            ep = m[27] ? {ip, dp, tp} : 24'h0;
         if (acc_wr)
            m = spr_req.wdata & MASK;
      end
      @(posedge clock);
      #6;
      check(64'(q.size()), 64'h0);
      stop_test();
   end

   // default reset value of the register is zero
   function automatic logic [31:0] RESET_CHECK_VAL();
      return 32'h00000000;
   endfunction : RESET_CHECK_VAL
endmodule : tb
